// [rtl/bus_arb_map.vh]
`ifndef BUS_ARB_MAP_VH
`define BUS_ARB_MAP_VH

// ****************************************
// arbitration constants
// ****************************************

// number of processor request lines
`define ARB_NUM_LINES 6
// width of the strapped processor identifier
`define ARB_ID_W 3
// identifier code meaning single-processor system
`define ARB_ID_SINGLE 3'h0
// identifier code of the first request line
`define ARB_ID_FIRST 3'h1
// identifier code of the last request line
`define ARB_ID_LAST 3'h6
// value for "no bus master"
`define ARB_NO_MASTER 3'h0
// rotation pointer after reset: first line wins first
`define ARB_LAST_RESET 3'h6

// ****************************************
// synchroniser bit positions
// ****************************************

`define ARB_SY_REQ_LO 0
`define ARB_SY_REQ_HI 5
`define ARB_SY_HREQ 6
`define ARB_SY_HGNT 7
`define ARB_SY_PRIO 8
`define ARB_SY_ROT 9
`define ARB_SY_ID_LO 10
`define ARB_SY_ID_HI 12
`define ARB_SY_W 13
// reset value: every active-low line, priority line too, idles high;
// straps low. a low priority bit here would withhold dma after reset
`define ARB_SY_RESET 13'h01FF

`endif

// [rtl/bus_arbiter.v]
`timescale 1ns/1ps
`include "bus_arb_map.vh"

module bus_arbiter #(
   parameter NUM_LINES = `ARB_NUM_LINES
) (
   input wire clk,
   input wire arst_n,
   // strap and mode pins
   input wire [2:0] processor_id,
   input wire rotating_priority_select,
   // request lines, active low
   input wire [NUM_LINES-1:0] bus_request_line_n_i,
   output wire [NUM_LINES-1:0] bus_request_line_n_o,
   output wire [NUM_LINES-1:0] bus_request_line_n_oe_n,
   // shared open-drain priority access line
   input wire core_priority_access_n_i,
   output wire core_priority_access_n_o,
   output wire core_priority_access_n_oe_n,
   // host request and grant
   input wire host_bus_request_n,
   input wire host_bus_grant_n_i,
   output wire host_bus_grant_n_o,
   output wire host_bus_grant_n_oe_n,
   // user side
   input wire core_req,
   input wire dma_req,
   output wire bus_master,
   output wire core_access,
   output wire dma_access,
   output wire [2:0] current_master
);

   // ****************************************
   // declarations
   // ****************************************

   reg own_want_r;
   reg own_want_nxt;
   reg [2:0] master_r;
   reg [2:0] master_nxt;
   reg [2:0] last_r;
   reg [2:0] last_nxt;
   reg host_grant_r;
   reg host_grant_nxt;
   reg bus_master_r;
   reg bus_master_nxt;
   reg [NUM_LINES-1:0] line_raw;
   reg [NUM_LINES-1:0] own_oe_n;
   wire [`ARB_SY_W-1:0] sy_in;
   wire [`ARB_SY_W-1:0] sy_out;
   wire [NUM_LINES-1:0] req_act;
   wire [2:0] id_s;
   wire rot_s;
   wire hreq_act;
   wire hgnt_act;
   wire prio_act;
   wire [2:0] rot_base;
   wire single;
   wire host_hold;
   wire [2:0] winner;
   wire am_master;
   wire grantor;
   integer i;

   // ****************************************
   // priority function
   // ****************************************

   // pick next master; rotating search starts after last master
   function [2:0] pick;
      input [NUM_LINES-1:0] req;
      input rot;
      input [2:0] last;
      integer k;
      integer tmp;
      reg [2:0] idx;
      reg found;
      begin
         pick = `ARB_NO_MASTER;
         found = 1'b0;
         idx = 3'h0;
         tmp = 0;
         for (k = 0; k < NUM_LINES; k = k + 1) begin
            if (rot) begin
               tmp = (last + k) % NUM_LINES;
            end else begin
               tmp = k;
            end
            idx = tmp[2:0];
            if (!found && req[idx]) begin
               found = 1'b1;
               pick = idx + `ARB_ID_FIRST;
            end
         end
      end
   endfunction

   // ****************************************
   // pin sampling
   // ****************************************

   // own line re-enters through the same two flops so that all
   // processors see every request with equal latency
   always @* begin
      line_raw = bus_request_line_n_i;
      own_oe_n = {NUM_LINES{1'b1}};
      for (i = 0; i < NUM_LINES; i = i + 1) begin
         if (id_s == i + 1) begin
            line_raw[i] = ~own_want_r;
            own_oe_n[i] = 1'b0;
         end
      end
   end

   assign sy_in = {processor_id, rotating_priority_select,
                   core_priority_access_n_i, host_bus_grant_n_i,
                   host_bus_request_n, line_raw};

   pin_sync #(
      .WIDTH(`ARB_SY_W),
      .RST_VAL(`ARB_SY_RESET)
   ) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .din(sy_in),
      .dout(sy_out)
   );

   // decoded sampled levels, active high internally
   // lines active low
   assign req_act = ~sy_out[`ARB_SY_REQ_HI:`ARB_SY_REQ_LO];
   assign hreq_act = ~sy_out[`ARB_SY_HREQ];
   assign hgnt_act = ~sy_out[`ARB_SY_HGNT];
   assign prio_act = ~sy_out[`ARB_SY_PRIO];
   assign rot_s = sy_out[`ARB_SY_ROT];
   // strap assumed static; followed only through the sync
   assign id_s = sy_out[`ARB_SY_ID_HI:`ARB_SY_ID_LO];
   assign single = (id_s == `ARB_ID_SINGLE);

   // ****************************************
   // arbitration
   // ****************************************

   assign host_hold = hreq_act | hgnt_act | host_grant_r;

   // releasing master is rotation base
   // with no master the last one released still counts
   assign rot_base = (master_r != `ARB_NO_MASTER) ? master_r : last_r;

   // mode sampled every cycle, no latching
   assign winner = pick(req_act, rot_s, rot_base);

   assign am_master = single ? own_want_r : (master_r == id_s);

   // the master grants the host; with no master, line one answers
   assign grantor = am_master | ((master_r == `ARB_NO_MASTER) &&
                    (single || id_s == `ARB_ID_FIRST));

   // master tracking, evaluated identically on every processor
   always @* begin
      master_nxt = master_r;
      last_nxt = last_r;
      if (host_hold) begin
         master_nxt = master_r;
      end else if (master_r != `ARB_NO_MASTER &&
                   req_act[master_r - `ARB_ID_FIRST]) begin
         master_nxt = master_r;
      end else begin
         master_nxt = winner;
         if (master_r != `ARB_NO_MASTER) begin
            last_nxt = master_r;
         end
      end
   end

   // own request: dma-only demand withdrawn while priority access pulls
   always @* begin
      own_want_nxt = core_req | (dma_req & ~prio_act);
   end

   // host grant held until host drops its request
   always @* begin
      host_grant_nxt = host_grant_r;
      if (!hreq_act) begin
         host_grant_nxt = 1'b0;
      end else if (grantor && !hgnt_act) begin
         host_grant_nxt = 1'b1;
      end
   end

   // bus ownership; released as soon as host asks
   always @* begin
      bus_master_nxt = am_master & own_want_r & ~hreq_act & ~host_grant_r &
                       ~hgnt_act & (single | ~(master_nxt != id_s));
   end

   // state registers
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         own_want_r <= 1'b0;
         master_r <= `ARB_NO_MASTER;
         last_r <= `ARB_LAST_RESET;
         host_grant_r <= 1'b0;
         bus_master_r <= 1'b0;
      end else begin
         own_want_r <= own_want_nxt;
         master_r <= master_nxt;
         last_r <= last_nxt;
         host_grant_r <= host_grant_nxt;
         bus_master_r <= bus_master_nxt;
      end
   end

   // ****************************************
   // pin drivers
   // ****************************************

   assign bus_request_line_n_o = {NUM_LINES{~own_want_r}};
   assign bus_request_line_n_oe_n = own_oe_n;

   // pull low only, slave core wanting bus
   assign core_priority_access_n_o = 1'b0;
   assign core_priority_access_n_oe_n = ~(core_req & ~bus_master_r &
                                          ~host_grant_r & ~single);

   // grant pin is open toward others while not granting
   assign host_bus_grant_n_o = 1'b0; // low = granted
   assign host_bus_grant_n_oe_n = ~host_grant_r;

   // ****************************************
   // user side
   // ****************************************

   assign bus_master = bus_master_r;
   assign current_master = master_r;
   assign core_access = bus_master_r & core_req;
   assign dma_access = bus_master_r & dma_req & ~core_req & ~prio_act;

endmodule // bus_arbiter

// [rtl/pin_sync.v]
`timescale 1ns/1ps

// ****************************************
// two-stage synchroniser, one per bit
// ****************************************

module pin_sync #(
   parameter WIDTH = 13,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   input wire clk,
   input wire arst_n,
   input wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] dout
);

   genvar g;

   // first flop feeds only the second
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         reg meta_r;
         reg sync_r;
         always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               meta_r <= RST_VAL[g];
               sync_r <= RST_VAL[g];
            end else begin
               meta_r <= din[g];
               sync_r <= meta_r;
            end
         end
         assign dout[g] = sync_r;
      end
   endgenerate

endmodule // pin_sync

// [tb/bus_arb_properties.sv]
`timescale 1ns/1ps
// ****
// arbiter port checks
// ****
module bus_arb_properties #(
   parameter NUM_LINES = 6
) (
   input wire clk,
   input wire arst_n,
   input wire [2:0] processor_id,
   input wire [NUM_LINES-1:0] bus_request_line_n_oe_n,
   input wire core_priority_access_n_o,
   input wire core_priority_access_n_oe_n,
   input wire core_priority_access_n_i,
   input wire host_bus_request_n,
   input wire host_bus_grant_n_i,
   input wire host_bus_grant_n_oe_n,
   input wire core_req,
   input wire bus_master,
   input wire dma_access,
   input wire [2:0] current_master
);
   reg [2:0] rc_r;
   // edges since reset; straps need two to pass the synchroniser
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) rc_r <= 3'h0;
      else if (rc_r != 3'h7) rc_r <= rc_r + 3'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_one_line: assert property ($countones(~bus_request_line_n_oe_n) <= 1)
      else $error("more than one request line driven");
   a_id_map: assert property (rc_r > 3'h2 && processor_id == 3'h1 |->
      bus_request_line_n_oe_n == 6'h3e)
      else $error("identifier one does not drive line one only");
   a_prio_drain: assert property (!core_priority_access_n_o &&
      (core_priority_access_n_oe_n || core_req && !bus_master))
      else $error("priority line driven wrongly");
   a_dma_yield: assert property (!core_priority_access_n_i [*3] |-> !dma_access)
      else $error("dma kept bus under priority access");
   a_host_wins: assert property (!host_bus_request_n [*4] |=> !bus_master)
      else $error("bus kept against host request");
   // grant held
   // request must have stood long enough to pass the two sync flops
   a_grant_keep: assert property (!host_bus_request_n [*3] ##0
      !host_bus_grant_n_oe_n |=> !host_bus_grant_n_oe_n)
      else $error("host grant dropped early");
   a_grant_soon: assert property ((!host_bus_request_n && rc_r > 3'h2 &&
      processor_id == 3'h1 && current_master <= 3'h1) [*5] |-> !host_bus_grant_n_oe_n)
      else $error("host grant late");
   a_master_keep: assert property ((core_req && host_bus_request_n &&
      host_bus_grant_n_i) [*3] ##0 bus_master |=> bus_master)
      else $error("master lost bus while requesting");
endmodule // bus_arb_properties

bind bus_arbiter bus_arb_properties #(.NUM_LINES(NUM_LINES)) u_props (
   .clk, .arst_n, .processor_id,
   .bus_request_line_n_oe_n, .core_priority_access_n_o, .core_priority_access_n_oe_n,
   .core_priority_access_n_i, .host_bus_request_n, .host_bus_grant_n_i,
   .host_bus_grant_n_oe_n, .core_req, .bus_master, .dma_access, .current_master);

// [tb/bus_peer_model.sv]
`timescale 1ns/1ps
// ****
// peers and host on the shared bus
// ****
module bus_peer_model (
   input wire clk,
   input wire [5:0] want,
   input wire prio_want,
   input wire host_want,
   output reg [5:0] line_n,
   output reg prio_n,
   output reg host_bus_request_n
);
   initial begin
      line_n = 6'h3f;
      prio_n = 1'b1;
      host_bus_request_n = 1'b1;
   end
   always @(posedge clk) begin
      line_n <= #1 ~(want & 6'h3e);
      prio_n <= #1 ~prio_want;
      host_bus_request_n <= #1 ~host_want;
   end
endmodule // bus_peer_model

// [tb/multiproc_bus_arbitration_tb_top.sv]
`timescale 1ns/1ps
// ****
// arbiter bench
// ****
module multiproc_bus_arbitration_tb_top;
   reg clk, arst_n, rot, core_req, dma_req, prio_want, host_want;
   reg [2:0] pid;
   reg [5:0] want;
   wire [5:0] peer_n, lo, oe_n;
   wire peer_prio_n, prio_o, prio_oe_n, hreq_n, hgnt_o, hgnt_oe_n, bm, ca, da;
   wire [2:0] cm;
   integer n_errors, num_checks, i;
   // wired lines with pull-ups
   wire [5:0] line_w = peer_n & (lo | oe_n);
   wire prio_w = peer_prio_n & (prio_o | prio_oe_n);
   wire hgnt_w = hgnt_o | hgnt_oe_n;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   bus_arbiter u_dut (.clk(clk), .arst_n(arst_n), .processor_id(pid),
      .rotating_priority_select(rot), .bus_request_line_n_i(line_w), .bus_request_line_n_o(lo),
      .bus_request_line_n_oe_n(oe_n), .core_priority_access_n_i(prio_w),
      .core_priority_access_n_o(prio_o), .core_priority_access_n_oe_n(prio_oe_n),
      .host_bus_request_n(hreq_n), .host_bus_grant_n_i(hgnt_w), .host_bus_grant_n_o(hgnt_o),
      .host_bus_grant_n_oe_n(hgnt_oe_n), .core_req(core_req), .dma_req(dma_req),
      .bus_master(bm), .core_access(ca), .dma_access(da), .current_master(cm));
   bus_peer_model u_peer (.clk(clk), .want(want), .prio_want(prio_want), .host_want(host_want),
      .line_n(peer_n), .prio_n(peer_prio_n), .host_bus_request_n(hreq_n));
   task check(input [7:0] got, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // inputs move 1 ns after the edge
   task cyc(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   // select moves only here, in one step
   task do_reset(input [2:0] id, input r);
      begin
         arst_n = 1'b0;
         pid = id;
         rot = r;
         {core_req, dma_req, prio_want, host_want, want} = 10'h000;
         cyc(4);
         arst_n = 1'b1;
         cyc(3);
      end
   endtask
   task wait_master(input [2:0] m);
      begin
         for (i = 0; i < 20 && cm !== m; i = i + 1) cyc(1);
         check(cm, m);
      end
   endtask
   task t_single;
      begin
         do_reset(3'h0, 1'b0);
         core_req = 1'b1;
         cyc(2);
         check(bm, 1'b1);
         check(oe_n, 6'h3f);
         core_req = 1'b0;
      end
   endtask
   // peer 2 holds, we queue, peer 2 leaves: fixed picks 1, rotating 3
   task t_arb(input r, input [2:0] nxt);
      begin
         do_reset(3'h1, r);
         want = 6'h06;
         wait_master(3'h2);
         core_req = 1'b1;
         cyc(4);
         check(bm, 1'b0);
         check(prio_oe_n, 1'b0);
         want = 6'h04;
         wait_master(nxt);
         cyc(2);
         check(ca, nxt == 3'h1);
         core_req = 1'b0;
         want = 6'h00;
      end
   endtask
   task t_host;
      begin
         do_reset(3'h1, 1'b0);
         core_req = 1'b1;
         wait_master(3'h1);
         host_want = 1'b1;
         cyc(6);
         check(bm, 1'b0);
         cyc(5);
         check(hgnt_oe_n, 1'b0);
         check(hgnt_w, 1'b0);
         host_want = 1'b0;
         cyc(6);
         check(hgnt_oe_n, 1'b1);
         core_req = 1'b0;
      end
   endtask
   task t_prio;
      begin
         do_reset(3'h1, 1'b0);
         prio_want = 1'b1;
         dma_req = 1'b1;
         cyc(6);
         check(lo[0] | oe_n[0], 1'b1);
         prio_want = 1'b0;
         // master id may linger from the withdrawn request; wait for ownership
         for (i = 0; i < 20 && bm !== 1'b1; i = i + 1) cyc(1);
         check(bm, 1'b1);
         check(cm, 3'h1);
         check(da, 1'b1);
         prio_want = 1'b1;
         cyc(4);
         check(da, 1'b0);
         {dma_req, prio_want} = 2'h0;
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d errors %0d", num_checks, n_errors);
         if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   // whole run is well under two hundred cycles
   initial begin
      #(25 * 2000);
      n_errors = n_errors + 1;
      tally_and_finish;
   end
   initial begin
      n_errors = 0;
      num_checks = 0;
      t_single;
      t_arb(1'b0, 3'h1);
      t_arb(1'b1, 3'h3);
      t_host;
      t_prio;
      tally_and_finish;
   end
endmodule // multiproc_bus_arbitration_tb_top
